// File: cgp_pkg.sv
// Package for the clock gating and PLL setup block: field layouts,
// reset values, source codes and timing counts.
// Assumes every file of the block imports it whole.
package cgp_pkg;
   // Widths and counts of the block
   localparam int unsigned NUM_PERIPH = 32;
   localparam int unsigned NUM_PROG = 2;
   localparam int unsigned NUM_SRC = 4;
   localparam int unsigned LOCK_CNT_W = 11;
   localparam int unsigned FREQ_W = 16;
   localparam int unsigned PRESCALE_FIELD_CNT_W = 7;
   // Source codes; also the index into the synchronised input vector
   localparam logic [1:0] SRC_SLOW = 2'h0;
   localparam logic [1:0] SRC_MAIN = 2'h1;
   localparam logic [1:0] SRC_PLLA = 2'h2;
   localparam logic [1:0] SRC_PLLB = 2'h3;
   // Programmable clock configuration word
   localparam int unsigned PCK_CSS_LO = 0;
   localparam int unsigned PCK_PRESCALE_FIELD_LO = 2;
   localparam int unsigned PCK_CFG_W = 5;
   localparam logic [2:0] PRESCALE_FIELD_MAX = 3'h6;
   localparam logic [PCK_CFG_W-1:0] PCK_CFG_RST = 5'h00;
   // Main oscillator configuration word
   localparam int unsigned MOR_EN_BIT = 0;
   localparam int unsigned MOR_OSC_STARTUP_COUNT_LO = 8;
   localparam int unsigned MOR_OSC_STARTUP_COUNT_W = 8;
   localparam int unsigned OSC_TICKS_PER_COUNT = 8;
   // PLL configuration words
   localparam int unsigned PLL_DIV_LO = 0;
   localparam int unsigned PLL_DIV_W = 8;
   localparam int unsigned PLL_COUNT_LO = 8;
   localparam int unsigned PLL_COUNT_W = 6;
   localparam int unsigned PLL_MUL_LO = 16;
   localparam int unsigned PLL_MUL_W = 11;
   localparam int unsigned PLLA_SRC_LO = 30;
   localparam int unsigned USB_DIV_LO = 28;
   localparam logic [31:0] CFG_WORD_RST = 32'h0000_0000;
   // Frequency measurement window in slow clock periods
   localparam logic [4:0] MEASURE_SLOW_PERIODS = 5'h10;
   typedef enum logic [1:0] {
      CGP_MEAS_IDLE = 2'b00,
      CGP_MEAS_SYNC = 2'b01,
      CGP_MEAS_COUNT = 2'b10,
      CGP_MEAS_DONE = 2'b11
   } cgp_meas_t;
endpackage : cgp_pkg

// File: cgp_lock_counter.sv
// Slow-clock countdown used for PLL lock and oscillator start-up.
// Assumes tick is a one-cycle pulse per slow clock period, same clock.
`timescale 1ns/1ns
`default_nettype none
module cgp_lock_counter
   import cgp_pkg::*;
#(
   parameter int unsigned W = LOCK_CNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic clear,
   input wire logic tick,
   output logic done
);
   logic [W-1:0] cnt_r;
   logic armed_r;

   // A load restarts the count and drops done; done rises after load_val ticks, or after one tick for zero
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         cnt_r <= '0;
         armed_r <= 1'b0;
         done <= 1'b0;
      end else if (load) begin
         cnt_r <= load_val;
         armed_r <= 1'b1;
         done <= 1'b0;
      end else if (armed_r && tick) begin
         // A zero count still waits one tick, so done is never combinational
         if (cnt_r <= W'(1)) begin
            armed_r <= 1'b0;
            done <= 1'b1;
         end else begin
            cnt_r <= cnt_r - W'(1);
         end
      end
   end
endmodule : cgp_lock_counter
`default_nettype wire

// File: cgp_prescaler.sv
// Power-of-two prescaler for a sampled clock level, with output gate.
// Assumes src is already synchronised to clk.
`timescale 1ns/1ns
`default_nettype none
module cgp_prescaler
   import cgp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic src,
   input wire logic [2:0] prescale_field,
   output logic clk_out,
   output logic src_edge
);
   logic src_prev_r;
   logic [PRESCALE_FIELD_CNT_W-1:0] cnt_r;
   logic [2:0] prescale_field_eff;
   logic [PRESCALE_FIELD_CNT_W:0] taps;
   logic tap;

   // Codes above the largest ratio are clamped to divide by 64
   assign prescale_field_eff = (prescale_field > PRESCALE_FIELD_MAX) ? PRESCALE_FIELD_MAX : prescale_field;
   // Slot 0 is the raw source, slot k the counter bit dividing by 2**k; no index leaves range
   assign taps = {cnt_r, src};
   assign tap = taps[prescale_field_eff];

   // Count source rising edges; bit k-1 toggles at source / 2**k
   always_ff @(posedge clk) begin
      if (rst || !en) begin
         cnt_r <= '0;
      end else if (src && !src_prev_r) begin
         cnt_r <= cnt_r + PRESCALE_FIELD_CNT_W'(1);
      end
   end

   // Registered output, held low while disabled
   always_ff @(posedge clk) begin
      if (rst) begin
         src_prev_r <= 1'b0;
         src_edge <= 1'b0;
         clk_out <= 1'b0;
      end else begin
         src_prev_r <= src;
         src_edge <= src && !src_prev_r;
         clk_out <= en ? tap : 1'b0;
      end
   end
endmodule : cgp_prescaler
`default_nettype wire

// File: cgp_clock_ctrl.sv
// Clock gating and PLL setup: peripheral clock gates, two programmable
// clock outputs, oscillator start-up, frequency measure and PLL lock.
// Assumes write strobes are one-cycle pulses on clk; clock pins arrive
// asynchronously and are sampled, so sources must be well below clk/2.
`timescale 1ns/1ns
`default_nettype none
module cgp_clock_ctrl
   import cgp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic slow_clk,
   input wire logic main_clk,
   input wire logic pll_a_clk,
   input wire logic pll_b_clk,
   input wire logic periph_clk_enable_we,
   input wire logic [NUM_PERIPH-1:0] periph_clk_enable_data,
   input wire logic periph_clk_disable_we,
   input wire logic [NUM_PERIPH-1:0] periph_clk_disable_data,
   input wire logic sys_clk_enable_we,
   input wire logic [NUM_PROG-1:0] sys_clk_enable_data,
   input wire logic sys_clk_disable_we,
   input wire logic [NUM_PROG-1:0] sys_clk_disable_data,
   input wire logic [NUM_PROG-1:0] prog_clock_config_we,
   input wire logic [PCK_CFG_W-1:0] prog_clock_config_data,
   input wire logic main_osc_config_we,
   input wire logic [31:0] main_osc_config_data,
   input wire logic pll_a_config_we,
   input wire logic [31:0] pll_a_config_data,
   input wire logic pll_b_config_we,
   input wire logic [31:0] pll_b_config_data,
   output logic [NUM_PERIPH-1:0] periph_clk_status,
   output logic [NUM_PROG-1:0] sys_clk_status,
   output logic [NUM_PROG-1:0] prog_clock_output,
   output logic [NUM_PROG-1:0] prog_ready,
   output logic osc_stable_flag,
   output logic measure_ready_flag,
   output logic [FREQ_W-1:0] freq_count_field,
   output logic pll_a_lock_flag,
   output logic pll_b_lock_flag,
   output logic pll_a_run,
   output logic pll_b_run,
   output logic usb_clk
);
   logic [NUM_SRC-1:0] sync1_r;
   logic [NUM_SRC-1:0] sync2_r;
   logic [NUM_SRC-1:0] prev_r;
   logic [NUM_SRC-1:0] rise;
   logic slow_tick;
   logic main_tick;
   logic [31:0] osc_cfg_r;
   logic [31:0] pll_a_cfg_r;
   logic [31:0] pll_b_cfg_r;
   logic [LOCK_CNT_W-1:0] osc_load_val;
   cgp_meas_t meas_state_r;
   logic [4:0] meas_slow_r;

   // Two-stage samplers for every clock pin; index equals the source code
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end else begin
         sync1_r <= {pll_b_clk, pll_a_clk, main_clk, slow_clk};
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   assign rise = sync2_r & ~prev_r;
   assign slow_tick = rise[SRC_SLOW];
   assign main_tick = rise[SRC_MAIN];

   // Peripheral gates: set and clear are one-hot by identifier; set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         periph_clk_status <= '0;
      end else begin
         // Bit n gates peripheral n, so zero bits keep their state
         periph_clk_status <= (periph_clk_status
            & ~(periph_clk_disable_we ? periph_clk_disable_data : '0))
            | (periph_clk_enable_we ? periph_clk_enable_data : '0);
      end
   end

   // Programmable output enables, same set-wins convention
   always_ff @(posedge clk) begin
      if (rst) begin
         sys_clk_status <= '0;
      end else begin
         sys_clk_status <= (sys_clk_status
            & ~(sys_clk_disable_we ? sys_clk_disable_data : '0))
            | (sys_clk_enable_we ? sys_clk_enable_data : '0);
      end
   end

   // One configuration, prescaler and ready flag per programmable output
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PROG; gi++) begin : g_prog
         logic [PCK_CFG_W-1:0] cfg_r;
         logic src_edge;

         always_ff @(posedge clk) begin
            if (rst) begin
               cfg_r <= PCK_CFG_RST;
            end else if (prog_clock_config_we[gi]) begin
               cfg_r <= prog_clock_config_data;
            end
         end

         // No glitch guard here: a live change can emit a runt pulse
         cgp_prescaler u_prescale_field (
            .clk(clk),
            .rst(rst),
            .en(sys_clk_status[gi]),
            .src(sync2_r[cfg_r[PCK_CSS_LO +: 2]]),
            .prescale_field(cfg_r[PCK_PRESCALE_FIELD_LO +: 3]),
            .clk_out(prog_clock_output[gi]),
            .src_edge(src_edge)
         );

         // Ready once a source edge passed through the new setting
         always_ff @(posedge clk) begin
            if (rst || prog_clock_config_we[gi] || !sys_clk_status[gi]) begin
               prog_ready[gi] <= 1'b0;
            end else if (src_edge) begin
               prog_ready[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // Configuration words; bit 29 of PLL A is stored as written
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_cfg_r <= CFG_WORD_RST;
         pll_a_cfg_r <= CFG_WORD_RST;
         pll_b_cfg_r <= CFG_WORD_RST;
      end else begin
         if (main_osc_config_we) begin
            osc_cfg_r <= main_osc_config_data;
         end
         if (pll_a_config_we) begin
            pll_a_cfg_r <= pll_a_config_data;
         end
         if (pll_b_config_we) begin
            pll_b_cfg_r <= pll_b_config_data;
         end
      end
   end

   // A PLL runs only with a live divider and a nonzero multiplier
   always_ff @(posedge clk) begin
      if (rst) begin
         pll_a_run <= 1'b0;
         pll_b_run <= 1'b0;
      end else begin
         pll_a_run <= (pll_a_cfg_r[PLL_DIV_LO +: PLL_DIV_W] != '0)
            && (pll_a_cfg_r[PLL_MUL_LO +: PLL_MUL_W] != '0);
         pll_b_run <= (pll_b_cfg_r[PLL_DIV_LO +: PLL_DIV_W] != '0)
            && (pll_b_cfg_r[PLL_MUL_LO +: PLL_MUL_W] != '0);
      end
   end

   // Oscillator start-up: 8 slow ticks per count unit
   assign osc_load_val = LOCK_CNT_W'(OSC_TICKS_PER_COUNT)
      * LOCK_CNT_W'(main_osc_config_data[MOR_OSC_STARTUP_COUNT_LO +: MOR_OSC_STARTUP_COUNT_W]);

   cgp_lock_counter u_osc (
      .clk(clk),
      .rst(rst),
      .load(main_osc_config_we && main_osc_config_data[MOR_EN_BIT]),
      .load_val(osc_load_val),
      .clear(main_osc_config_we && !main_osc_config_data[MOR_EN_BIT]),
      .tick(slow_tick),
      .done(osc_stable_flag)
   );

   // Every write reloads the lock count and drops the flag until relock
   cgp_lock_counter u_lock_a (
      .clk(clk),
      .rst(rst),
      .load(pll_a_config_we),
      .load_val(LOCK_CNT_W'(pll_a_config_data[PLL_COUNT_LO +: PLL_COUNT_W])),
      .clear(1'b0),
      .tick(slow_tick),
      .done(pll_a_lock_flag)
   );

   cgp_lock_counter u_lock_b (
      .clk(clk),
      .rst(rst),
      .load(pll_b_config_we),
      .load_val(LOCK_CNT_W'(pll_b_config_data[PLL_COUNT_LO +: PLL_COUNT_W])),
      .clear(1'b0),
      .tick(slow_tick),
      .done(pll_b_lock_flag)
   );

   // USB clock: PLL B sample divided by 1, 2, 4 or 8
   cgp_prescaler u_usb (
      .clk(clk),
      .rst(rst),
      .en(1'b1),
      .src(sync2_r[SRC_PLLB]),
      .prescale_field({1'b0, pll_b_cfg_r[USB_DIV_LO +: 2]}),
      .clk_out(usb_clk),
      .src_edge()
   );

   // Frequency measure: start at a slow edge after stable, count 16 periods
   always_ff @(posedge clk) begin
      if (rst || !osc_stable_flag) begin
         meas_state_r <= CGP_MEAS_IDLE;
         meas_slow_r <= '0;
         freq_count_field <= '0;
         measure_ready_flag <= 1'b0;
      end else begin
         unique case (meas_state_r)
            CGP_MEAS_IDLE: begin
               meas_state_r <= CGP_MEAS_SYNC;
            end
            CGP_MEAS_SYNC: begin
               if (slow_tick) begin
                  meas_state_r <= CGP_MEAS_COUNT;
                  meas_slow_r <= '0;
                  freq_count_field <= '0;
               end
            end
            CGP_MEAS_COUNT: begin
               if (main_tick) begin
                  freq_count_field <= freq_count_field + FREQ_W'(1);
               end
               if (slow_tick) begin
                  meas_slow_r <= meas_slow_r + 5'h1;
                  if (meas_slow_r + 5'h1 == MEASURE_SLOW_PERIODS) begin
                     meas_state_r <= CGP_MEAS_DONE;
                     measure_ready_flag <= 1'b1;
                  end
               end
            end
            CGP_MEAS_DONE: begin
               meas_state_r <= CGP_MEAS_DONE; // Result held until oscillator drops
            end
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Slow ticks since the last PLL A write, for the lock timing check
   logic [LOCK_CNT_W-1:0] a_ticks_r;
   logic [LOCK_CNT_W-1:0] a_expect_r;
   always_ff @(posedge clk) begin
      if (rst || pll_a_config_we) begin
         a_ticks_r <= '0;
         a_expect_r <= rst ? LOCK_CNT_W'(1) : ((pll_a_config_data[PLL_COUNT_LO +: PLL_COUNT_W]
            == '0) ? LOCK_CNT_W'(1) : LOCK_CNT_W'(pll_a_config_data[PLL_COUNT_LO +: PLL_COUNT_W]));
      end else if (slow_tick && !pll_a_lock_flag) begin
         a_ticks_r <= a_ticks_r + LOCK_CNT_W'(1);
      end
   end

   // Only counts above one leave room for two clear cycles before relock
   sequence s_a_written;
      pll_a_config_we && (pll_a_config_data[PLL_COUNT_LO +: PLL_COUNT_W] > 6'h01);
   endsequence
   sequence s_a_unlocked_then_lock;
      !pll_a_lock_flag ##1 pll_a_lock_flag;
   endsequence

   AST_PCLK_ENABLE: assert property (periph_clk_enable_we |=>
      ((periph_clk_status & $past(periph_clk_enable_data)) == $past(periph_clk_enable_data)))
      else $error("peripheral clock not enabled after enable write");
   AST_PCLK_STOP_NOW: assert property ((periph_clk_disable_we && !periph_clk_enable_we) |=>
      ((periph_clk_status & $past(periph_clk_disable_data)) == '0))
      else $error("peripheral clock still running after disable write");
   AST_PCLK_OFF_AFTER_RESET: assert property ($past(rst) |-> periph_clk_status == '0)
      else $error("peripheral clock on right after reset");
   AST_PCLK_ZERO_KEEPS: assert property ((periph_clk_enable_we && !periph_clk_disable_we) |=>
      periph_clk_status == ($past(periph_clk_status) | $past(periph_clk_enable_data)))
      else $error("enable write changed clocks outside its one bits");
   AST_PROG_OFF_LOW: assert property (!sys_clk_status[0] |=> !prog_clock_output[0])
      else $error("disabled programmable clock output not low");
   AST_PROG_READY_DROP: assert property (prog_clock_config_we[0] |=> !prog_ready[0])
      else $error("programmable ready not cleared by configuration write");
   AST_PLL_A_RELOCK_CLEAR: assert property (s_a_written |=> !pll_a_lock_flag[*2])
      else $error("PLL A lock flag not cleared by configuration write");
   AST_PLL_A_LOCK_TIME: assert property (s_a_unlocked_then_lock |-> a_ticks_r == a_expect_r)
      else $error("PLL A lock flag rose after wrong number of slow ticks");
   AST_FREQ_HELD: assert property ((measure_ready_flag && $past(measure_ready_flag)) |->
      $stable(freq_count_field))
      else $error("frequency count changed while ready");

   // Every write drops the flag at the next edge, whatever the count
   AST_PLL_A_CLEAR_NEXT: assert property (pll_a_config_we |=> !pll_a_lock_flag)
      else $error("PLL A lock flag still set after configuration write");
   AST_PLL_B_CLEAR_NEXT: assert property (pll_b_config_we |=> !pll_b_lock_flag)
      else $error("PLL B lock flag still set after configuration write");
   AST_OSC_RESTART: assert property (main_osc_config_we |=> !osc_stable_flag)
      else $error("oscillator stable flag still set after configuration write");
   // Run flags trail the write by two edges: one to store, one to decode
   AST_PLL_A_RUN: assert property (pll_a_config_we |-> ##2
      (pll_a_run == (($past(pll_a_config_data[PLL_DIV_LO +: PLL_DIV_W], 2) != '0)
      && ($past(pll_a_config_data[PLL_MUL_LO +: PLL_MUL_W], 2) != '0))))
      else $error("PLL A run flag does not follow divider and multiplier");
   AST_PLL_B_RUN: assert property (pll_b_config_we |-> ##2
      (pll_b_run == (($past(pll_b_config_data[PLL_DIV_LO +: PLL_DIV_W], 2) != '0)
      && ($past(pll_b_config_data[PLL_MUL_LO +: PLL_MUL_W], 2) != '0))))
      else $error("PLL B run flag does not follow divider and multiplier");
   AST_PROG1_OFF_LOW: assert property (!sys_clk_status[1] |=>
      !prog_clock_output[1])
      else $error("disabled second programmable output not low");
   AST_PROG_READY_OFF: assert property (!sys_clk_status[1] |=> !prog_ready[1])
      else $error("programmable ready set while output disabled");
   AST_SYS_ENABLE: assert property (sys_clk_enable_we |=>
      ((sys_clk_status & $past(sys_clk_enable_data)) == $past(sys_clk_enable_data)))
      else $error("programmable output not enabled after enable write");
   AST_MEAS_NEEDS_STABLE: assert property (!osc_stable_flag |=>
      !measure_ready_flag)
      else $error("measure ready while oscillator not stable");
endmodule : cgp_clock_ctrl
`default_nettype wire

// File: cgp_clk_model.sv
// Far-side clock sources for the clock block: slow, main and two PLL pins.
// Assumes a 10 ns system clock; every period here is a whole multiple of it.
`timescale 1ns/1ns
`default_nettype none
module cgp_clk_model #(
   parameter int SLOW_HALF = 80,
   parameter int MAIN_HALF = 20,
   parameter int PLLA_HALF = 30,
   parameter int PLLB_HALF = 40
) (
   output var logic slow_clk,
   output var logic main_clk,
   output var logic pll_a_clk,
   output var logic pll_b_clk
);
   // A 3 ns offset keeps pin edges away from the sampling edge, so counts stay exact
   initial begin
      slow_clk = 1'b0;
      #3;
      forever #(SLOW_HALF) slow_clk = ~slow_clk;
   end
   // Main oscillator runs free; its frequency is what the measure counts
   initial begin
      main_clk = 1'b0;
      #3;
      forever #(MAIN_HALF) main_clk = ~main_clk;
   end
   // PLL outputs run free as well; lock timing is the block's own business
   initial begin
      pll_a_clk = 1'b0;
      #3;
      forever #(PLLA_HALF) pll_a_clk = ~pll_a_clk;
   end
   initial begin
      pll_b_clk = 1'b0;
      #3;
      forever #(PLLB_HALF) pll_b_clk = ~pll_b_clk;
   end
endmodule : cgp_clk_model
`default_nettype wire

// File: cgp_clock_ctrl_tb_top.sv
// Self-checking bench for the clock block with clock-source model.
// Assumes slow period 16 clk, main 4, PLL A 6, PLL B 8 clk cycles.
`timescale 1ns/1ns
`default_nettype none
module cgp_clock_ctrl_tb_top;
   import cgp_pkg::*;
   logic clk, rst, slow_clk, main_clk, pll_a_clk, pll_b_clk;
   logic pe_we, pd_we, se_we, sd_we, mo_we, pa_we, pb_we;
   logic [1:0] pc_we, se_d, sd_d, scs, pco, prdy, ob;
   logic [31:0] pe_d, pd_d, mo_d, pa_d, pb_d, pcs;
   logic [4:0] pc_d;
   logic osc_f, meas_f, lock_a, lock_b, run_a, run_b, usb;
   logic [15:0] freq;
   int n_fail, n_compared, cyc, n;
   // Peripheral rows: enable data, disable data, status expected after both
   localparam logic [31:0] T_EN [6] = '{32'h0000_0110, 32'h0000_0000, 32'h8000_0001,
      32'h0000_0000, 32'h0000_0002, 32'h0000_0000};
   localparam logic [31:0] T_DIS [6] = '{32'h0000_0000, 32'h0000_0010, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0002, 32'hFFFF_FFFF};
   localparam logic [31:0] T_EXP [6] = '{32'h0000_0110, 32'h0000_0100, 32'h8000_0101,
      32'h8000_0101, 32'h8000_0103, 32'h0000_0000};
   // Programmable output rows: output, source, prescale; period = SRCP << prescale
   localparam int P_OUT [5] = '{0, 0, 1, 1, 0};
   localparam int P_SRC [5] = '{0, 1, 2, 3, 0};
   localparam int P_PRESCALE_FIELD [5] = '{0, 2, 1, 0, 6};
   localparam int SRCP [4] = '{16, 4, 6, 8};

   cgp_clk_model cgp_clk_model_i (.slow_clk(slow_clk), .main_clk(main_clk),
      .pll_a_clk(pll_a_clk), .pll_b_clk(pll_b_clk));
   cgp_clock_ctrl cgp_clock_ctrl_i (.clk(clk), .rst(rst), .slow_clk(slow_clk),
      .main_clk(main_clk), .pll_a_clk(pll_a_clk), .pll_b_clk(pll_b_clk),
      .periph_clk_enable_we(pe_we), .periph_clk_enable_data(pe_d),
      .periph_clk_disable_we(pd_we), .periph_clk_disable_data(pd_d),
      .sys_clk_enable_we(se_we), .sys_clk_enable_data(se_d),
      .sys_clk_disable_we(sd_we), .sys_clk_disable_data(sd_d),
      .prog_clock_config_we(pc_we), .prog_clock_config_data(pc_d),
      .main_osc_config_we(mo_we), .main_osc_config_data(mo_d),
      .pll_a_config_we(pa_we), .pll_a_config_data(pa_d),
      .pll_b_config_we(pb_we), .pll_b_config_data(pb_d),
      .periph_clk_status(pcs), .sys_clk_status(scs), .prog_clock_output(pco),
      .prog_ready(prdy), .osc_stable_flag(osc_f), .measure_ready_flag(meas_f),
      .freq_count_field(freq), .pll_a_lock_flag(lock_a), .pll_b_lock_flag(lock_b),
      .pll_a_run(run_a), .pll_b_run(run_b), .usb_clk(usb));

   // System clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic chk_rng(input int v, input int lo, input int hi);
      check(32'(v >= lo && v <= hi), 32'h0000_0001);
   endtask : chk_rng

   task automatic wrap_up;
      $display("counts: compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   // One-cycle write strobes; mask bits select which registers are written
   task automatic strobe(input logic [8:0] m);
      @(negedge clk);
      pe_we = m[0];
      pd_we = m[1];
      se_we = m[2];
      sd_we = m[3];
      pc_we = m[5:4];
      mo_we = m[6];
      pa_we = m[7];
      pb_we = m[8];
      @(negedge clk);
      {pe_we, pd_we, se_we, sd_we, pc_we, mo_we, pa_we, pb_we} = 9'h000;
   endtask : strobe

   function automatic logic pick(input int s);
      case (s)
         0: return prdy[0];
         1: return prdy[1];
         2: return osc_f;
         3: return meas_f;
         4: return lock_a;
         5: return lock_b;
         6: return pco[0];
         7: return pco[1];
         default: return usb;
      endcase
   endfunction : pick

   // Bounded wait for a level; a wait that runs out is reported as a mismatch
   task automatic wait_lvl(input int s, input logic v, inout int cnt);
      int g;
      g = 0;
      while (pick(s) !== v && g < 4000) begin
         @(negedge clk);
         g++;
         cnt++;
      end
      if (g >= 4000) check(32'(pick(s)), 32'(v));
   endtask : wait_lvl

   // Cycles between two rising edges of a monitored clock output
   task automatic period(input int s, output int p);
      int d;
      d = 0;
      p = 0;
      wait_lvl(s, 1'b0, d);
      wait_lvl(s, 1'b1, d);
      wait_lvl(s, 1'b0, p);
      wait_lvl(s, 1'b1, p);
   endtask : period

   // Hang guard, well above the few thousand cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      {pe_we, pd_we, se_we, sd_we, pc_we, mo_we, pa_we, pb_we} = 9'h000;
      {pe_d, pd_d, mo_d, pa_d, pb_d} = 160'h0;
      {se_d, sd_d, pc_d} = 9'h000;
      n_fail = 0;
      n_compared = 0;
      cyc = 0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check(pcs, 32'h0000_0000);
      check(32'({scs, pco, prdy, osc_f, meas_f, lock_a, lock_b, run_a, run_b, usb, freq}),
         32'h0000_0000);
      $display("test reset done");
      // No peripheral is busy here, so disabling at any time is safe
      for (int i = 0; i < 6; i++) begin
         pe_d = T_EN[i];
         pd_d = T_DIS[i];
         strobe(9'h003);
         check(pcs, T_EXP[i]);
      end
      // A second reset in mid-run must drop every gate again
      pe_d = 32'hFFFF_FFFF;
      strobe(9'h001);
      check(pcs, 32'hFFFF_FFFF);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check(pcs, 32'h0000_0000);
      $display("test peripheral gates done");
      // Disable, configure, enable: reconfiguring a running output may glitch
      for (int i = 0; i < 5; i++) begin
         ob = 2'h1 << P_OUT[i];
         sd_d = ob;
         strobe(9'h008);
         check(32'(scs & ob), 32'h0000_0000);
         pc_d = {3'(P_PRESCALE_FIELD[i]), 2'(P_SRC[i])};
         strobe({3'h0, ob, 4'h0});
         check(32'(prdy & ob), 32'h0000_0000);
         se_d = ob;
         strobe(9'h004);
         check(32'(scs & ob), 32'(ob));
         n = 0;
         wait_lvl(P_OUT[i], 1'b1, n);
         period(6 + P_OUT[i], n);
         check(n, SRCP[P_SRC[i]] << P_PRESCALE_FIELD[i]);
      end
      period(7, n);
      check(n, 8);
      sd_d = 2'h1;
      strobe(9'h008);
      repeat (2) @(negedge clk);
      check(32'({scs, pco[0]}), 32'h0000_0004);
      $display("test programmable outputs done");
      mo_d = 32'h0000_0201;
      strobe(9'h040);
      check(32'(osc_f), 32'h0000_0000);
      n = 0;
      wait_lvl(2, 1'b1, n);
      chk_rng(n, 15 * 16 - 1, 16 * 16 + 4);
      n = 0;
      wait_lvl(3, 1'b1, n);
      check(32'(freq), 32'h0000_0040);
      chk_rng(n, 16 * 16 - 2, 17 * 16 + 8);
      mo_d = 32'h0000_0000;
      strobe(9'h040);
      check(32'(osc_f), 32'h0000_0000);
      $display("test oscillator done");
      // Bit 29 is always written as one for PLL A; run trails the write by two edges
      pa_d = 32'h2003_0605;
      strobe(9'h080);
      check(32'(lock_a), 32'h0000_0000);
      @(negedge clk);
      check(32'({lock_a, run_a}), 32'h0000_0001);
      n = 0;
      wait_lvl(4, 1'b1, n);
      chk_rng(n, 5 * 16 - 1, 6 * 16 + 4);
      pa_d = 32'h2003_0600;
      strobe(9'h080);
      @(negedge clk);
      check(32'({lock_a, run_a}), 32'h0000_0000);
      pa_d = 32'h2003_0605;
      strobe(9'h080);
      @(negedge clk);
      check(32'(run_a), 32'h0000_0001);
      pa_d = 32'h2000_0605;
      strobe(9'h080);
      @(negedge clk);
      check(32'({lock_a, run_a}), 32'h0000_0000);
      pb_d = 32'h0004_0805;
      strobe(9'h100);
      @(negedge clk);
      check(32'({lock_b, run_b}), 32'h0000_0001);
      n = 0;
      wait_lvl(5, 1'b1, n);
      chk_rng(n, 7 * 16 - 1, 8 * 16 + 4);
      // The first pulse after a divide change may be short, so the second period counts
      for (int u = 0; u < 3; u++) begin
         pb_d = 32'h0004_0805 | (32'(u) << 28);
         strobe(9'h100);
         n = 0;
         wait_lvl(5, 1'b1, n);
         period(8, n);
         period(8, n);
         check(n, 8 << u);
      end
      pb_d = 32'h0000_0805;
      strobe(9'h100);
      @(negedge clk);
      check(32'({lock_b, run_b}), 32'h0000_0000);
      $display("test PLL and USB done");
      wrap_up();
   end
endmodule : cgp_clock_ctrl_tb_top
`default_nettype wire
